// >>> hw/iox_pkg.sv
// Constants shared by the port I/O execution unit.
// Assumes one clock; one clock state of the processor equals one clock here.
package iox_pkg;
    localparam int          IOX_SYS_CLK_MHZ = 100;
    // Clock states per machine cycle for block input
    localparam logic [2:0]  IOX_BI_M1_T     = 3'h4;
    localparam logic [2:0]  IOX_BI_M2_T     = 3'h5;
    localparam logic [2:0]  IOX_BI_M3_T     = 3'h3;
    localparam logic [2:0]  IOX_BI_M4_T     = 3'h4;
    localparam logic [2:0]  IOX_BI_M5_T     = 3'h5;
    // Immediate-port output: 4, 3, 4
    localparam logic [2:0]  IOX_OI_M1_T     = 3'h4;
    localparam logic [2:0]  IOX_OI_M2_T     = 3'h3;
    localparam logic [2:0]  IOX_OI_M3_T     = 3'h4;
    // Register-indirect output: 4, 4, 4
    localparam logic [2:0]  IOX_OR_M_T      = 3'h4;
    localparam logic [15:0] IOX_PC_REWIND   = 16'h0002;
    // Operation codes on the command port
    localparam logic [2:0]  IOX_OP_INC_SGL  = 3'h0;
    localparam logic [2:0]  IOX_OP_INC_RPT  = 3'h1;
    localparam logic [2:0]  IOX_OP_DEC_SGL  = 3'h2;
    localparam logic [2:0]  IOX_OP_DEC_RPT  = 3'h3;
    localparam logic [2:0]  IOX_OP_OUT_IMM  = 3'h4;
    localparam logic [2:0]  IOX_OP_OUT_REG  = 3'h5;
    // Register field codes
    localparam logic [2:0]  IOX_R_B         = 3'h0;
    localparam logic [2:0]  IOX_R_C         = 3'h1;
    localparam logic [2:0]  IOX_R_D         = 3'h2;
    localparam logic [2:0]  IOX_R_E         = 3'h3;
    localparam logic [2:0]  IOX_R_H         = 3'h4;
    localparam logic [2:0]  IOX_R_L         = 3'h5;
    localparam logic [2:0]  IOX_R_A         = 3'h7;
    // Flag bit positions
    localparam int          IOX_F_C         = 0;
    localparam int          IOX_F_N         = 1;
    localparam int          IOX_F_Z         = 6;
endpackage : iox_pkg

// >>> hw/iox_regsel.sv
// Register-field selector for the register-indirect output.
// Assumes register values are stable while the field is sampled.
`timescale 1ns/100ps
`default_nettype none
module iox_regsel
    import iox_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Field and register file
    input  wire logic [2:0] sel,
    input  wire logic [7:0] reg_b,
    input  wire logic [7:0] reg_c,
    input  wire logic [7:0] reg_d,
    input  wire logic [7:0] reg_e,
    input  wire logic [7:0] reg_h,
    input  wire logic [7:0] reg_l,
    input  wire logic [7:0] reg_a,
    // Registered result
    output logic      [7:0] data_out
);
    logic [7:0] pick;
    always_comb begin
        unique case (sel)
            IOX_R_B: pick = reg_b;
            IOX_R_C: pick = reg_c;
            IOX_R_D: pick = reg_d;
            IOX_R_E: pick = reg_e;
            IOX_R_H: pick = reg_h;
            IOX_R_L: pick = reg_l;
            IOX_R_A: pick = reg_a;
            default: pick = 8'h00;                 // 110 is not a register
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= 8'h00;
        end else begin
            data_out <= pick;
        end
    end
endmodule : iox_regsel
`default_nettype wire

// >>> hw/iox_exec.sv
// Execution unit for port input block transfers and direct output.
// Assumes memory and ports answer within the documented clock states.
// Function
// - Port C low, count B high address
// - Write captured byte to pointer address
// - Incrementing single: count down, pointer up
// - Decrementing single: count and pointer down
// - Single block input takes 16 states
// - Zero when count reaches zero, subtract set
// - Repeat increment: pointer up, count down
// - Repeat decrement: pointer and count down
// - Repeat ends at zero, else rewind PC
// - Interrupts and one 5-state refresh between bytes
// - Count zero at start moves 256 bytes
// - Continuing iteration 21 states, last 16
// - Immediate output: operand low, accumulator high
// - Indirect output: C low, B high
// - Decode register field B..L, A
// - Read port byte before memory write
`timescale 1ns/100ps
`default_nettype none
module iox_exec
    import iox_pkg::*;
(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    // Command
    input  wire logic        START,
    input  wire logic [2:0]  OP,
    input  wire logic [2:0]  REG_SEL,
    input  wire logic [7:0]  IMM,
    output logic             BUSY,
    output logic             DONE,
    // Register file in
    input  wire logic [7:0]  REG_A,
    input  wire logic [7:0]  REG_B,
    input  wire logic [7:0]  REG_C,
    input  wire logic [7:0]  REG_D,
    input  wire logic [7:0]  REG_E,
    input  wire logic [7:0]  REG_H,
    input  wire logic [7:0]  REG_L,
    input  wire logic [7:0]  FLAGS_IN,
    input  wire logic [15:0] PC_IN,
    input  wire logic        INT_PEND,
    // Register file out
    output logic [7:0]       COUNT_OUT,
    output logic [15:0]      POINTER_PAIR_OUT,
    output logic [7:0]       FLAGS_OUT,
    output logic [15:0]      PC_OUT,
    output logic             INT_TAKE,
    // Bus
    output logic [15:0]      ADDR,
    output logic [7:0]       DOUT,
    input  wire logic [7:0]  DIN,
    output logic             IO_RD,
    output logic             IO_WR,
    output logic             MEM_WR,
    output logic             REFRESH
);
    typedef enum {S_IDLE, S_FETCH, S_PIN, S_MWR, S_UPD, S_RFSH, S_OOP, S_OWR} iox_st_t;

    // Bus strobes live in the state, so every bus output leaves a flop
    typedef struct packed {
        iox_st_t     st;
        logic [2:0]  tcnt;
        logic [2:0]  op;
        logic [7:0]  port;
        logic [7:0]  cnt;
        logic [15:0] ptr;
        logic [7:0]  hold;
        logic [7:0]  flags;
        logic [15:0] pc;
        logic [15:0] addr;
        logic [7:0]  dout;
        logic        io_rd;
        logic        io_wr;
        logic        mem_wr;
        logic        rfsh;
        logic        done;
        logic        int_take;
    } iox_state_t;

    iox_state_t s_r;
    iox_state_t s_nxt;
    logic [7:0] sel_data;
    logic [7:0] din_q1_r;
    logic [7:0] din_q2_r;

    // Port data arrives from off-chip logic
    // Two flops cost latency; the port byte must settle early in the read cycle
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            din_q1_r <= 8'h00;
            din_q2_r <= 8'h00;
        end else begin
            din_q1_r <= DIN;
            din_q2_r <= din_q1_r;
        end
    end

    // Registered select keeps the output-data path short
    iox_regsel u_regsel (
        .clk      (SYS_CLK),
        .rst_n    (RST_N),
        .sel      (REG_SEL),
        .reg_b    (REG_B),
        .reg_c    (REG_C),
        .reg_d    (REG_D),
        .reg_e    (REG_E),
        .reg_h    (REG_H),
        .reg_l    (REG_L),
        .reg_a    (REG_A),
        .data_out (sel_data)
    );

    function automatic logic is_repeat(input logic [2:0] op);
        is_repeat = (op == IOX_OP_INC_RPT) || (op == IOX_OP_DEC_RPT);
    endfunction : is_repeat

    function automatic logic is_dec(input logic [2:0] op);
        is_dec = (op == IOX_OP_DEC_SGL) || (op == IOX_OP_DEC_RPT);
    endfunction : is_dec

    logic       last_t;
    logic [7:0] cnt_dec;
    always_comb begin
        s_nxt          = s_r;
        s_nxt.done     = 1'b0;
        s_nxt.int_take = 1'b0;
        s_nxt.tcnt     = s_r.tcnt + 3'h1;
        last_t         = 1'b0;
        cnt_dec        = s_r.cnt - 8'h01;     // 0 wraps to ff: 256 bytes
        unique case (s_r.st)
            S_IDLE: begin
                // B, C, H, L, flags and PC are latched here; A, IMM and the selected register are read later, in S_OOP
                s_nxt.tcnt = 3'h0;
                if (START) begin
                    s_nxt.st    = S_FETCH;
                    s_nxt.tcnt  = 3'h1;
                    s_nxt.op    = OP;
                    s_nxt.port  = REG_C;
                    s_nxt.cnt   = REG_B;
                    s_nxt.ptr   = {REG_H, REG_L};
                    s_nxt.flags = FLAGS_IN;
                    s_nxt.pc    = PC_IN;
                end
            end
            S_FETCH: begin
                // First machine cycle: opcode fetch timing, 4 states for all
                if (s_r.tcnt == IOX_BI_M1_T) begin
                    s_nxt.tcnt = 3'h1;
                    if (s_r.op == IOX_OP_OUT_IMM || s_r.op == IOX_OP_OUT_REG) begin
                        s_nxt.st = S_OOP;
                    end else begin
                        s_nxt.st    = S_PIN;
                        s_nxt.addr  = {s_r.cnt, s_r.port};
                        s_nxt.io_rd = 1'b1;
                    end
                end
            end
            S_PIN: begin
                // Byte taken on the last read state, two flops behind the pin
                if (s_r.tcnt == IOX_BI_M2_T) begin
                    s_nxt.hold   = din_q2_r;
                    s_nxt.io_rd  = 1'b0;
                    s_nxt.st     = S_MWR;
                    s_nxt.tcnt   = 3'h1;
                    s_nxt.addr   = s_r.ptr;
                    s_nxt.dout   = din_q2_r;
                    s_nxt.mem_wr = 1'b1;
                end
            end
            S_MWR: begin
                if (s_r.tcnt == IOX_BI_M3_T) begin
                    s_nxt.mem_wr = 1'b0;
                    s_nxt.st     = S_UPD;
                    s_nxt.tcnt   = 3'h1;
                end
            end
            S_UPD: begin
                if (s_r.tcnt == IOX_BI_M4_T) begin
                    s_nxt.cnt = cnt_dec;
                    s_nxt.ptr = is_dec(s_r.op) ? s_r.ptr - 16'h0001 : s_r.ptr + 16'h0001;
                    s_nxt.flags[IOX_F_Z] = (cnt_dec == 8'h00);
                    s_nxt.flags[IOX_F_N] = 1'b1;
                    s_nxt.tcnt = 3'h1;
                    // Testing after the decrement lets an interrupt resume the reissued op
                    if (is_repeat(s_r.op) && cnt_dec != 8'h00) begin
                        s_nxt.pc   = s_r.pc - IOX_PC_REWIND;
                        s_nxt.st   = S_RFSH;
                        s_nxt.rfsh = 1'b1;
                    end else begin
                        last_t     = 1'b1;
                    end
                end
            end
            S_RFSH: begin
                if (s_r.tcnt == IOX_BI_M5_T) begin
                    s_nxt.rfsh     = 1'b0;
                    s_nxt.int_take = INT_PEND;
                    last_t         = 1'b1;
                end
            end
            S_OOP: begin
                // Accumulator and operand are read late, at the address phase
                if (s_r.op == IOX_OP_OUT_IMM && s_r.tcnt == IOX_OI_M2_T) begin
                    s_nxt.addr  = {REG_A, IMM};
                    s_nxt.dout  = REG_A;
                    s_nxt.io_wr = 1'b1;
                    s_nxt.st    = S_OWR;
                    s_nxt.tcnt  = 3'h1;
                end else if (s_r.op == IOX_OP_OUT_REG && s_r.tcnt == IOX_OR_M_T) begin
                    s_nxt.addr  = {s_r.cnt, s_r.port};
                    s_nxt.dout  = sel_data;
                    s_nxt.io_wr = 1'b1;
                    s_nxt.st    = S_OWR;
                    s_nxt.tcnt  = 3'h1;
                end
            end
            S_OWR: begin
                // both end on a 4-state write cycle
                if (s_r.tcnt == IOX_OI_M3_T) begin
                    s_nxt.io_wr = 1'b0;
                    last_t      = 1'b1;
                end
            end
            default: s_nxt.st = S_IDLE;
        endcase
        if (last_t) begin
            s_nxt.st   = S_IDLE;
            s_nxt.done = 1'b1;
            s_nxt.tcnt = 3'h0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_r <= '{st: S_IDLE, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Every output but BUSY is a state flop
    assign BUSY             = (s_r.st != S_IDLE);
    assign DONE             = s_r.done;
    assign COUNT_OUT        = s_r.cnt;
    assign POINTER_PAIR_OUT = s_r.ptr;
    assign FLAGS_OUT        = s_r.flags;
    assign PC_OUT           = s_r.pc;
    assign INT_TAKE         = s_r.int_take;
    assign ADDR             = s_r.addr;
    assign DOUT             = s_r.dout;
    assign IO_RD            = s_r.io_rd;
    assign IO_WR            = s_r.io_wr;
    assign MEM_WR           = s_r.mem_wr;
    assign REFRESH          = s_r.rfsh;

    // Cycle counter from start to done, for timing checks
    // Counts only while busy, so on the DONE cycle it holds the full op length
    logic [4:0] run_r;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            run_r <= 5'h00;
        end else if (s_r.st == S_IDLE) begin
            run_r <= 5'h00;
        end else begin
            run_r <= run_r + 5'h01;
        end
    end

    // Bus shape of block input
    AST_RDADDR: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(IO_RD) |-> ADDR == {COUNT_OUT, s_r.port})
        else $error("port read address wrong");
    AST_MWR: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(MEM_WR) |-> ADDR == POINTER_PAIR_OUT && $past(IO_RD) && DOUT == s_r.hold)
        else $error("memory write wrong");

    // Register updates at the end of each byte
    AST_INCS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s_r.st == S_UPD && s_r.tcnt == IOX_BI_M4_T && !is_dec(s_r.op)) |=>
        COUNT_OUT == $past(COUNT_OUT) - 8'h01 && POINTER_PAIR_OUT == $past(POINTER_PAIR_OUT) + 16'h0001)
        else $error("increment step wrong");
    AST_DECS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s_r.st == S_UPD && s_r.tcnt == IOX_BI_M4_T && is_dec(s_r.op)) |=>
        COUNT_OUT == $past(COUNT_OUT) - 8'h01 && POINTER_PAIR_OUT == $past(POINTER_PAIR_OUT) - 16'h0001)
        else $error("decrement step wrong");
    AST_FLAG: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s_r.st == S_UPD && s_r.tcnt == IOX_BI_M4_T) |=> FLAGS_OUT[IOX_F_N]
        && FLAGS_OUT[IOX_F_Z] == (COUNT_OUT == 8'h00) && FLAGS_OUT[IOX_F_C] == $past(FLAGS_OUT[IOX_F_C]))
        else $error("flags wrong");

    // Repeat control, refresh and interrupt window
    AST_REWIND: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(REFRESH) |-> PC_OUT == $past(PC_OUT) - IOX_PC_REWIND && COUNT_OUT != 8'h00)
        else $error("rewind wrong");
    AST_RPTEND: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (DONE && is_repeat(s_r.op) && !$past(REFRESH)) |-> COUNT_OUT == 8'h00 && FLAGS_OUT[IOX_F_Z])
        else $error("repeat ended early");
    AST_RFSH: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(REFRESH) |-> REFRESH [*5] ##1 !REFRESH)
        else $error("refresh length wrong");
    AST_INTTK: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        INT_TAKE |-> $past(REFRESH) && $past(INT_PEND))
        else $error("interrupt taken outside gap");

    // Clock-state counts, checked on the cycle that DONE stands
    AST_SGL16: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (DONE && !is_repeat(s_r.op) && !$past(IO_WR)) |-> run_r == 5'd16)
        else $error("single not 16");
    AST_RPT21: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (DONE && $past(REFRESH)) |-> run_r == 5'd21)
        else $error("repeat not 21");
    AST_RPT16: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (DONE && is_repeat(s_r.op) && !$past(REFRESH)) |-> run_r == 5'd16)
        else $error("last repeat not 16");
    AST_OUT11: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (DONE && $past(IO_WR) && s_r.op == IOX_OP_OUT_IMM) |-> run_r == 5'd11)
        else $error("out not 11");
    AST_OUT12: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (DONE && $past(IO_WR) && s_r.op == IOX_OP_OUT_REG) |-> run_r == 5'd12)
        else $error("out not 12");

    // Port output address and data
    AST_IMMOUT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(IO_WR) && s_r.op == IOX_OP_OUT_IMM |-> ADDR == {$past(REG_A), $past(IMM)} && DOUT == $past(REG_A))
        else $error("immediate output wrong");
    AST_REGOUT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(IO_WR) && s_r.op == IOX_OP_OUT_REG |-> ADDR == {COUNT_OUT, s_r.port})
        else $error("indirect output address wrong");

    COV_RPT: cover property (@(posedge SYS_CLK) disable iff (!RST_N) $rose(REFRESH));
    COV_OUTI: cover property (@(posedge SYS_CLK) disable iff (!RST_N) IO_WR && s_r.op == IOX_OP_OUT_IMM);
    COV_OUTR: cover property (@(posedge SYS_CLK) disable iff (!RST_N) IO_WR && s_r.op == IOX_OP_OUT_REG);
    COV_Z: cover property (@(posedge SYS_CLK) disable iff (!RST_N) DONE && FLAGS_OUT[IOX_F_Z]);
    COV_INT: cover property (@(posedge SYS_CLK) disable iff (!RST_N) INT_TAKE);
endmodule : iox_exec
`default_nettype wire

// >>> test/iox_bus_model.sv
// Memory and one I/O port sitting on the unit's shared buses.
// Assumes the unit's strobes are registered and change just after SYS_CLK rises.
`timescale 1ns/100ps
`default_nettype none
module iox_bus_model (
    // Clock
    input  wire logic        clk,
    // Bus from the unit
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  dout,
    input  wire logic        io_rd,
    input  wire logic        io_wr,
    input  wire logic        mem_wr,
    // Byte the port offers
    input  wire logic [7:0]  port_byte,
    // Data bus back to the unit
    output logic      [7:0]  din
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  junk_r = 8'h00;
    logic [15:0] rd_addr;
    logic [15:0] wr_addr;
    logic [7:0]  wr_data;

    // Released bus toggles each cycle, so a late capture never matches by luck
    assign din = io_rd ? port_byte : junk_r;

    always_ff @(posedge clk) begin
        junk_r <= ~junk_r;
        if (io_rd) begin
            rd_addr <= addr;
        end
        if (mem_wr) begin
            mem[addr] <= dout;
        end
        if (io_wr) begin
            wr_addr <= addr;
            wr_data <= dout;
        end
    end
endmodule : iox_bus_model
`default_nettype wire

// >>> test/iox_exec_test.sv
// Self-checking bench for the port I/O execution unit.
// Assumes the bus model answers port reads and keeps memory and port writes.
`timescale 1ns/100ps
`default_nettype none
module iox_exec_test import iox_pkg::*;;
    logic        sys_clk, rst_n, start, int_pend, busy, done, int_take, io_rd, io_wr, mem_wr, refresh;
    logic [2:0]  op, reg_sel;
    logic [7:0]  imm, reg_a, reg_b, reg_c, reg_d, reg_e, reg_h, reg_l, flags_in, din, port_byte;
    logic [7:0]  count_out, flags_out, dout;
    logic [15:0] pc_in, ptr_out, pc_out, addr;
    int          err_count, check_count, cycles, cyc, n_rf, n_rd, n_mw, n_wr, n_it, n_bz, rd_at, mw_at;

    iox_exec u_iox_exec (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .START(start), .OP(op), .REG_SEL(reg_sel), .IMM(imm),
        .BUSY(busy), .DONE(done), .REG_A(reg_a), .REG_B(reg_b), .REG_C(reg_c), .REG_D(reg_d),
        .REG_E(reg_e), .REG_H(reg_h), .REG_L(reg_l), .FLAGS_IN(flags_in), .PC_IN(pc_in),
        .INT_PEND(int_pend), .COUNT_OUT(count_out), .POINTER_PAIR_OUT(ptr_out), .FLAGS_OUT(flags_out),
        .PC_OUT(pc_out), .INT_TAKE(int_take), .ADDR(addr), .DOUT(dout), .DIN(din), .IO_RD(io_rd),
        .IO_WR(io_wr), .MEM_WR(mem_wr), .REFRESH(refresh));

    iox_bus_model u_iox_bus_model (
        .clk(sys_clk), .addr(addr), .dout(dout), .io_rd(io_rd), .io_wr(io_wr), .mem_wr(mem_wr),
        .port_byte(port_byte), .din(din));

    always #5 sys_clk = ~sys_clk;

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("BAD t=%0t run hung", $time);
            tally_and_finish();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chk_n(input int got, input int exp, input string what);
        check_count++;
        if (got != exp) begin
            err_count++;
            $display("BAD t=%0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask : chk_n

    // One operation from START to DONE, tallying bus strobes on the way
    task automatic run(input logic [2:0] o, input logic [7:0] b, input logic [15:0] pp, input logic [7:0] pb);
        {cyc, n_rf, n_rd, n_mw, n_wr, n_it, n_bz, rd_at, mw_at} = '0;
        @(posedge sys_clk);
        op <= o;
        reg_b <= b;
        reg_h <= pp[15:8];
        reg_l <= pp[7:0];
        port_byte <= pb;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        do begin
            @(negedge sys_clk);
            cyc++;
            if (io_rd === 1'b1 && rd_at == 0) rd_at = cyc;
            if (mem_wr === 1'b1 && mw_at == 0) mw_at = cyc;
            n_rd += int'(io_rd === 1'b1);
            n_mw += int'(mem_wr === 1'b1);
            n_wr += int'(io_wr === 1'b1);
            n_rf += int'(refresh === 1'b1);
            n_it += int'(int_take === 1'b1);
            n_bz += int'(busy === 1'b1);
        end while (done !== 1'b1 && cyc < 40);
    endtask : run

    task automatic t_single;
        @(posedge sys_clk);
        reg_c <= 8'h07;
        flags_in <= 8'h01;
        pc_in <= 16'h0300;
        run(IOX_OP_INC_SGL, 8'h10, 16'h1000, 8'h7b);
        chk(u_iox_bus_model.rd_addr, 16'h1007, "port addr");
        chk(u_iox_bus_model.mem[16'h1000], 16'h007b, "mem byte");
        chk_n(int'(rd_at < mw_at), 1, "read before write");
        chk(count_out, 16'h000f, "count");
        chk(ptr_out, 16'h1001, "pointer");
        chk({flags_out[IOX_F_Z], flags_out[IOX_F_N], flags_out[IOX_F_C]}, 16'h0003, "flags");
        chk_n(cyc, 17, "cycles");
        chk_n(n_rd * 10 + n_mw, 53, "read and write length");
        chk_n(n_bz, 16, "busy length");
        @(posedge sys_clk);
        flags_in <= 8'h00;
        run(IOX_OP_DEC_SGL, 8'h01, 16'h0000, 8'hc4);
        chk(u_iox_bus_model.mem[16'h0000], 16'h00c4, "mem byte");
        chk(count_out, 16'h0000, "count");
        chk(ptr_out, 16'hffff, "pointer");
        chk({flags_out[IOX_F_Z], flags_out[IOX_F_N], flags_out[IOX_F_C]}, 16'h0006, "flags");
        chk_n(cyc, 17, "cycles");
        $display("single block input done");
    endtask : t_single

    // Reissues START while the unit rewinds PC, feeding back count and pointer
    task automatic t_repeat(input logic [2:0] o, input logic [7:0] b0, input int n_exp);
        logic [7:0]  b;
        logic [15:0] pp;
        logic [15:0] pp_e;
        logic        last;
        int          n;
        b = b0;
        pp = 16'h1000;
        n = 0;
        do begin
            @(posedge sys_clk);
            int_pend <= (n == 1);
            pc_in <= 16'h0200;
            run(o, b, pp, 8'(8'h51 + n));
            pp_e = (o == IOX_OP_INC_RPT) ? pp + 16'h0001 : pp - 16'h0001;
            last = (b == 8'h01);
            chk(u_iox_bus_model.mem[pp], 16'(8'(8'h51 + n)), "mem byte");
            chk(count_out, 16'(8'(b - 8'h01)), "count");
            chk(ptr_out, pp_e, "pointer");
            chk(flags_out[IOX_F_Z], 16'(last), "zero flag");
            chk(pc_out, last ? 16'h0200 : 16'h01fe, "pc");
            chk_n(cyc, last ? 17 : 22, "cycles");
            chk_n(n_rf, last ? 0 : 5, "refresh length");
            chk_n(n_it, int'(n == 1 && !last), "interrupt taken");
            b = 8'(b - 8'h01);
            pp = pp_e;
            n++;
        end while (b != 8'h00 && n < 300);
        @(posedge sys_clk);
        int_pend <= 1'b0;
        chk_n(n, n_exp, "bytes moved");
        $display("repeat block input done");
    endtask : t_repeat

    task automatic t_out;
        logic [7:0] exp_r [8];
        exp_r = '{8'h10, 8'h01, 8'h5a, 8'he5, 8'h4c, 8'h3d, 8'h00, 8'ha7};
        @(posedge sys_clk);
        reg_a <= 8'h23;
        imm <= 8'h01;
        run(IOX_OP_OUT_IMM, 8'h10, 16'h4c3d, 8'h00);
        chk(u_iox_bus_model.wr_addr, 16'h2301, "port addr");
        chk(u_iox_bus_model.wr_data, 16'h0023, "port byte");
        chk_n(cyc * 10 + n_wr, 124, "cycles and write length");
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            reg_a <= 8'ha7;
            reg_c <= 8'h01;
            reg_d <= 8'h5a;
            reg_e <= 8'he5;
            reg_sel <= 3'(i);
            run(IOX_OP_OUT_REG, 8'h10, 16'h4c3d, 8'h00);
            chk(u_iox_bus_model.wr_addr, 16'h1001, "port addr");
            chk(u_iox_bus_model.wr_data, 16'(exp_r[i]), "port byte");
            chk_n(cyc, 13, "cycles");
        end
        $display("port output done");
    endtask : t_out

    initial begin
        {sys_clk, rst_n, start, int_pend, op, reg_sel, imm, reg_a, reg_b, reg_c} = '0;
        {reg_d, reg_e, reg_h, reg_l, flags_in, port_byte, pc_in} = '0;
        {err_count, check_count, cycles} = '0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_single();
        t_repeat(IOX_OP_INC_RPT, 8'h03, 3);
        t_repeat(IOX_OP_DEC_RPT, 8'h00, 256);
        t_out();
        tally_and_finish();
    end
endmodule : iox_exec_test
`default_nettype wire
